// >>> dacsc_ctrl.sv
`timescale 1ns/1ps
module dacsc_ctrl #(
    parameter int DAC_BITS = dacsc_pkg::DACSC_DEF_BITS
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // io bus instruction, one cycle per executed instruction
    input wire logic io_valid,
    input wire logic [5:0] io_dev_code,
    input wire logic [2:0] io_xfer,
    input wire logic [1:0] io_fn,
    input wire logic [dacsc_pkg::DACSC_WORD_W-1:0] accumulator_source,
    // io bus answer
    output logic [dacsc_pkg::DACSC_WORD_W-1:0] io_read_data,
    output logic io_read_valid,
    output logic io_busy_flag,
    output logic io_done_flag,
    // converter bank
    output logic [dacsc_pkg::DACSC_CHAN_W-1:0] dac_channel,
    output logic [DAC_BITS-1:0] dac_data,
    output logic dac_convert,
    output logic hold_settling,
    // scope
    output logic [dacsc_pkg::DACSC_MODE_W-1:0] scope_mode,
    output logic scope_intensify,
    output logic scope_erase,
    input wire logic scope_erasing_pin
);
    import dacsc_pkg::*;

    // ------------------------------------------------------------
    // build checks
    // ------------------------------------------------------------
    generate
        if (DAC_BITS < DACSC_MIN_BITS || DAC_BITS > DACSC_MAX_BITS) begin : g_bad_width
            $error("converter width must be 8 to 14 bits");
        end
    endgenerate

    localparam logic [DACSC_SETTLE_W-1:0] SETTLE_LOAD =
        DACSC_SETTLE_W'(DACSC_HOLD_CHARGE_CYC);

    typedef struct packed {
        logic [DACSC_CHAN_W-1:0] channel;
        logic [DAC_BITS-1:0] data;
        logic convert;
        logic [DACSC_SETTLE_W-1:0] settle;
        logic settling;
        logic [DACSC_MODE_W-1:0] mode;
        logic intensify;
        logic erase;
        logic erase_flag;
        logic pin_seen;
        logic [DACSC_WORD_W-1:0] rd_data;
        logic rd_valid;
        logic busy;
        logic done;
    } dacsc_state_type;

    dacsc_state_type st, next_st;
    logic erasing_sync;
    logic hit;
    logic erasing_now;

    // ------------------------------------------------------------
    // operator erase line crosses into clk
    // ------------------------------------------------------------
    dacsc_sync u_erase_sync (
        .clk(clk),
        .nrst(nrst),
        .d(scope_erasing_pin),
        .q(erasing_sync)
    );

    // decode shared by every instruction to this card
    function automatic logic fn_is(input logic [1:0] fn, input logic [1:0] want);
        fn_is = (fn == want);
    endfunction : fn_is

    assign hit = io_valid && (io_dev_code == DACSC_DEV_CODE);
    // status covers program erase from request until the scope finishes
    assign erasing_now = st.erase_flag || erasing_sync;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.convert = 1'b0;
        next_st.intensify = 1'b0;
        next_st.erase = 1'b0;
        next_st.rd_valid = 1'b0;
        next_st.busy = 1'b0;
        next_st.done = 1'b0;
        // settle timer for hold capacitor charge, informative only
        if (st.settle != '0) begin
            next_st.settle = st.settle - 1'b1;
        end
        next_st.settling = (next_st.settle != '0);
        // program erase ends when the scope reports erasing then stops
        if (erasing_sync) begin
            next_st.pin_seen = st.erase_flag;
        end else if (st.pin_seen) begin
            next_st.erase_flag = 1'b0;
            next_st.pin_seen = 1'b0;
        end
        if (hit) begin
            case (io_xfer)
                DACSC_XFER_CHAN_SEL: begin
                    next_st.channel = accumulator_source[DACSC_CHAN_W-1:0];
                end
                DACSC_XFER_SAMPLE: begin
                    // upper accumulator bits dropped whatever their value
                    next_st.data = accumulator_source[DAC_BITS-1:0];
                    next_st.convert = 1'b1;
                    next_st.settle = SETTLE_LOAD;
                    next_st.settling = 1'b1;
                end
                DACSC_XFER_SCOPE_MODE: begin
                    next_st.mode = accumulator_source[DACSC_MODE_W-1:0];
                end
                DACSC_XFER_READ_ERASE: begin
                    next_st.rd_data = {{(DACSC_WORD_W-1){1'b0}}, erasing_now};
                    next_st.rd_valid = 1'b1;
                end
                default: begin
                end
            endcase
            // control functions touch only the scope, never the data path
            if (fn_is(io_fn, DACSC_FN_START)) begin
                next_st.intensify = 1'b1;
            end
            if (fn_is(io_fn, DACSC_FN_PULSE)) begin
                next_st.erase = 1'b1;
                next_st.erase_flag = 1'b1;
                next_st.pin_seen = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dac_channel = st.channel;
    assign dac_data = st.data;
    assign dac_convert = st.convert;
    assign hold_settling = st.settling;
    assign scope_mode = st.mode;
    assign scope_intensify = st.intensify;
    assign scope_erase = st.erase;
    assign io_read_data = st.rd_data;
    assign io_read_valid = st.rd_valid;
    assign io_busy_flag = st.busy;
    assign io_done_flag = st.done;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_foreign_ignored: assert property (@(posedge clk) disable iff (!nrst)
        io_valid && io_dev_code != DACSC_DEV_CODE |=> !dac_convert && !scope_intensify
        && !scope_erase && !io_read_valid && $stable(dac_channel) && $stable(scope_mode))
        else $error("instruction for another device changed state");
    a_flags_clear: assert property (@(posedge clk) disable iff (!nrst)
        !io_busy_flag && !io_done_flag)
        else $error("busy or done flag raised");
    a_chan_capture: assert property (@(posedge clk) disable iff (!nrst)
        hit && io_xfer == DACSC_XFER_CHAN_SEL
        |=> dac_channel == $past(accumulator_source[DACSC_CHAN_W-1:0]))
        else $error("channel selector not loaded");
    a_sample_convert: assert property (@(posedge clk) disable iff (!nrst)
        hit && io_xfer == DACSC_XFER_SAMPLE
        |=> dac_convert && dac_data == $past(accumulator_source[DAC_BITS-1:0]))
        else $error("data load did not start conversion");
    a_convert_cause: assert property (@(posedge clk) disable iff (!nrst)
        dac_convert |-> $past(hit) && $past(io_xfer) == DACSC_XFER_SAMPLE)
        else $error("conversion without data load");
    a_data_holds: assert property (@(posedge clk) disable iff (!nrst)
        !dac_convert |-> $stable(dac_data))
        else $error("converter data changed without load");
    // back-to-back starts are legal, so a second cycle high needs a start of its own
    a_start_intens: assert property (@(posedge clk) disable iff (!nrst)
        hit && io_fn == DACSC_FN_START |=> scope_intensify
        ##1 (!scope_intensify || $past(hit && io_fn == DACSC_FN_START)))
        else $error("start did not give one intensify pulse");
    a_pulse_erase: assert property (@(posedge clk) disable iff (!nrst)
        hit && io_fn == DACSC_FN_PULSE |=> scope_erase && erasing_now)
        else $error("pulse did not erase");
    a_mode_latch: assert property (@(posedge clk) disable iff (!nrst)
        hit && io_xfer == DACSC_XFER_SCOPE_MODE
        |=> scope_mode == $past(accumulator_source[DACSC_MODE_W-1:0]))
        else $error("scope mode not latched");
    a_status_word: assert property (@(posedge clk) disable iff (!nrst)
        io_read_valid |-> io_read_data[DACSC_WORD_W-1:1] == '0
        && io_read_data[0] == $past(erasing_now))
        else $error("erase status word malformed");
    a_settle_len: assert property (@(posedge clk) disable iff (!nrst)
        dac_convert |-> hold_settling [*8])
        else $error("hold settle window too short");
endmodule : dacsc_ctrl

// >>> dacsc_pkg.sv
package dacsc_pkg;
    // ------------------------------------------------------------
    // io instruction decode
    // ------------------------------------------------------------
    localparam logic [5:0] DACSC_DEV_CODE = 6'h13; // octal 23
    localparam logic [2:0] DACSC_XFER_NIO = 3'h0;
    localparam logic [2:0] DACSC_XFER_READ_ERASE = 3'h1; // read_erase_status
    localparam logic [2:0] DACSC_XFER_SAMPLE = 3'h2; // load_sample_word
    localparam logic [2:0] DACSC_XFER_CHAN_SEL = 3'h4; // load_channel_select
    localparam logic [2:0] DACSC_XFER_SCOPE_MODE = 3'h6; // load_scope_mode
    localparam logic [1:0] DACSC_FN_NONE = 2'h0;
    localparam logic [1:0] DACSC_FN_START = 2'h1;
    localparam logic [1:0] DACSC_FN_CLEAR = 2'h2;
    localparam logic [1:0] DACSC_FN_PULSE = 2'h3;
    // ------------------------------------------------------------
    // field layout (machine bit 15 is vector bit 0)
    // ------------------------------------------------------------
    localparam int DACSC_CHAN_W = 8;
    localparam int DACSC_WORD_W = 16;
    localparam int DACSC_MODE_W = 2;
    localparam int DACSC_MIN_BITS = 8;
    localparam int DACSC_MAX_BITS = 14;
    localparam int DACSC_DEF_BITS = 12;
    localparam logic [7:0] DACSC_CHAN_RESET = 8'h00;
    localparam logic [1:0] DACSC_MODE_STANDARD = 2'h0;
    localparam logic [1:0] DACSC_MODE_NONSTORE = 2'h1;
    localparam logic [1:0] DACSC_MODE_WRITE_THRU = 2'h2;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int DACSC_CLK_MHZ = 100;
    localparam int DACSC_HOLD_CHARGE_US = 15;
    localparam int DACSC_HOLD_CHARGE_CYC = DACSC_HOLD_CHARGE_US * DACSC_CLK_MHZ;
    localparam int DACSC_SETTLE_W = 11;
endpackage : dacsc_pkg

// >>> dacsc_sync.sv
`timescale 1ns/1ps
module dacsc_sync (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // asynchronous level in, filtered level out
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } dacsc_sync_state_type;

    dacsc_sync_state_type st, next_st;

    // ------------------------------------------------------------
    // three stages; level accepted once stages two and three agree
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.s1 = d;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3) begin
            next_st.q = st.s3;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.q;
endmodule : dacsc_sync

// >>> dacsc_scope_model.sv
`timescale 1ns/1ps
module dacsc_scope_model (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // scope lines
    input wire logic scope_erase,
    output logic scope_erasing_pin
);
    logic [4:0] left;

    // erase lasts a short fixed span; a real tube takes far longer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            left <= 5'h00;
        end else if (scope_erase) begin
            left <= 5'h14;
        end else if (left != 5'h00) begin
            left <= left - 5'h01;
        end
    end

    // status level seen by the control while the face is erasing
    assign scope_erasing_pin = (left != 5'h00);
endmodule : dacsc_scope_model

// >>> dacsc_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
    $display("ERROR %s expected %h seen %h", n, e, s); end end
module dacsc_ctrl_tb;
    import dacsc_pkg::*;
    localparam int B = 10;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic io_valid = 1'b0;
    logic [5:0] io_dev_code = 6'h00;
    logic [2:0] io_xfer = 3'h0;
    logic [1:0] io_fn = 2'h0;
    logic [15:0] accumulator_source = 16'h0000;
    logic [15:0] io_read_data;
    logic io_read_valid, io_busy_flag, io_done_flag, dac_convert, hold_settling;
    logic [7:0] dac_channel;
    logic [B-1:0] dac_data;
    logic [1:0] scope_mode;
    logic scope_intensify, scope_erase, scope_erasing_pin;
    int failures = 0;
    int compares = 0;
    logic [31:0] seed = 32'he84cf587;
    logic [7:0] e_ch = 8'h00;
    logic [B-1:0] e_dat = '0;
    logic [1:0] e_mode = 2'h0;

    // free-running bus clock
    always #5 clk = ~clk;

    dacsc_ctrl #(.DAC_BITS(B)) i_dacsc_ctrl (.clk(clk), .nrst(nrst), .io_valid(io_valid),
        .io_dev_code(io_dev_code), .io_xfer(io_xfer), .io_fn(io_fn),
        .accumulator_source(accumulator_source), .io_read_data(io_read_data),
        .io_read_valid(io_read_valid), .io_busy_flag(io_busy_flag),
        .io_done_flag(io_done_flag), .dac_channel(dac_channel), .dac_data(dac_data),
        .dac_convert(dac_convert), .hold_settling(hold_settling), .scope_mode(scope_mode),
        .scope_intensify(scope_intensify), .scope_erase(scope_erase),
        .scope_erasing_pin(scope_erasing_pin));
    dacsc_scope_model i_dacsc_scope_model (.clk(clk), .nrst(nrst), .scope_erase(scope_erase),
        .scope_erasing_pin(scope_erasing_pin));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        xorshift = y ^ (y << 5);
    endfunction : xorshift

    // the converter keeps only its low-order bits, upper bits are don't-care
    function automatic logic [B-1:0] conv(input logic [15:0] acc);
        conv = acc[B-1:0];
    endfunction : conv

    task automatic stop_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    // one instruction, checked 1 ns after the edge that takes it, then one idle cycle
    // so the strobe is never lowered and raised in the same time step
    task automatic ins(input logic [5:0] d, input logic [2:0] x, input logic [1:0] f,
                       input logic [15:0] a);
        logic hit;
        hit = (d == DACSC_DEV_CODE);
        io_valid = 1'b1;
        io_dev_code = d;
        io_xfer = x;
        io_fn = f;
        accumulator_source = a;
        @(posedge clk);
        #1;
        io_valid = 1'b0;
        if (hit && x == DACSC_XFER_CHAN_SEL) e_ch = a[7:0];
        if (hit && x == DACSC_XFER_SAMPLE) e_dat = conv(a);
        if (hit && x == DACSC_XFER_SCOPE_MODE) e_mode = a[1:0];
        `CHK("channel", e_ch, dac_channel)
        `CHK("data", e_dat, dac_data)
        `CHK("convert", hit && x == DACSC_XFER_SAMPLE, dac_convert)
        `CHK("intensify", hit && f == DACSC_FN_START, scope_intensify)
        `CHK("erase", hit && f == DACSC_FN_PULSE, scope_erase)
        `CHK("mode", e_mode, scope_mode)
        `CHK("read valid", hit && x == DACSC_XFER_READ_ERASE, io_read_valid)
        `CHK("busy done", 2'b00, {io_busy_flag, io_done_flag})
        @(posedge clk);
        #1;
    endtask : ins

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        #1;
        `CHK("reset", 12'h000, {dac_channel, scope_mode, scope_intensify, scope_erase})
        nrst = 1'b1;
        ins(DACSC_DEV_CODE, DACSC_XFER_CHAN_SEL, DACSC_FN_NONE, 16'h00ff);
        ins(DACSC_DEV_CODE, DACSC_XFER_SAMPLE, DACSC_FN_START, 16'h01ff);
        repeat (1498) @(posedge clk);
        #1;
        `CHK("settling", 1'b1, hold_settling)
        @(posedge clk);
        #1;
        `CHK("settling end", 1'b0, hold_settling)
        ins(DACSC_DEV_CODE, DACSC_XFER_SAMPLE, DACSC_FN_NONE, 16'hfe00);
        ins(DACSC_DEV_CODE, DACSC_XFER_SAMPLE, DACSC_FN_CLEAR, 16'h5e00);
        ins(6'h12, DACSC_XFER_SAMPLE, DACSC_FN_PULSE, 16'h0011);
        for (int m = 0; m < 4; m++) begin
            ins(DACSC_DEV_CODE, DACSC_XFER_SCOPE_MODE, DACSC_FN_START, {14'h3fff, m[1:0]});
        end
        // a read carrying pulse reports the prior status, the next one sees erasing
        ins(DACSC_DEV_CODE, DACSC_XFER_READ_ERASE, DACSC_FN_PULSE, 16'hffff);
        `CHK("status idle", 16'h0000, io_read_data)
        ins(DACSC_DEV_CODE, DACSC_XFER_READ_ERASE, DACSC_FN_NONE, 16'hffff);
        `CHK("status busy", 16'h0001, io_read_data)
        repeat (40) @(posedge clk);
        #1;
        ins(DACSC_DEV_CODE, DACSC_XFER_READ_ERASE, DACSC_FN_NONE, 16'hffff);
        `CHK("status done", 16'h0000, io_read_data)
        // random traffic; pulse is swapped for start so the status stays quiet
        for (int i = 0; i < 60; i++) begin
            seed = xorshift(seed);
            // a new channel is picked only once the last hold capacitor has charged
            if ((seed[0] || seed[6:1] == DACSC_DEV_CODE) && seed[9:7] == DACSC_XFER_CHAN_SEL) begin
                repeat (DACSC_HOLD_CHARGE_CYC) @(posedge clk);
                #1;
            end
            ins(seed[0] ? DACSC_DEV_CODE : seed[6:1], seed[9:7],
                (seed[11:10] == 2'h3) ? DACSC_FN_START : seed[11:10], seed[31:16]);
            if (seed[0] && seed[9:7] == DACSC_XFER_READ_ERASE) begin
                `CHK("random status", 16'h0000, io_read_data)
            end
        end
        nrst = 1'b0;
        #1;
        `CHK("reset again", 12'h000, {dac_channel, scope_mode, scope_intensify, scope_erase})
        stop_test();
    end

    // watchdog, several times the expected run length including charge waits
    initial begin
        #400000;
        failures++;
        stop_test();
    end
endmodule : dacsc_ctrl_tb
